// file: pkg/pso_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts of the serial output block
// Assumes: Byte-wide registers on a documented 8-bit address port
// Notes:   Definitions only
`ifndef PSO_DEFINES_SVH
`define PSO_DEFINES_SVH

`define PSO_ADDR_FRAC_44K1_H  8'h52
`define PSO_ADDR_BCLK_DIV     8'h54
`define PSO_ADDR_SO_CONFIG    8'h55
`define PSO_ADDR_CROSS_MAP    8'h56
`define PSO_ADDR_POST_DIV     8'h61
`define PSO_ADDR_OVERSAMPLING_CLOCK_MODE    8'h63
`define PSO_ADDR_FRAC_LOW     8'h64
`define PSO_ADDR_FRAC_HIGH    8'h65

`define PSO_RST_FRAC_44K1_H   8'h00
`define PSO_RST_BCLK_DIV      8'h03
`define PSO_RST_SO_CONFIG     8'h21
`define PSO_RST_CROSS_MAP     8'h00
`define PSO_RST_POST_DIV      8'h07
`define PSO_RST_OVERSAMPLING_CLOCK_MODE     8'h00
`define PSO_RST_FRAC_LOW      8'h46
`define PSO_RST_FRAC_HIGH     8'h5B

`define PSO_BIT_ORDER         6
`define PSO_BIT_PAD           5
`define PSO_BIT_POL           4
`define PSO_BIT_FMT           3
`define PSO_BIT_EDGE          2
`define PSO_BIT_MODE          0

`define PSO_SLOTS_16          7'h20
`define PSO_SLOTS_32          7'h40
`define PSO_POST_DIV_MASK     8'h1F

`endif

// file: pkg/pso_pkg.sv
// Purpose: Types of the serial output block
// Assumes: Used with package-qualified names only
// Notes:   Precision codes and cross-map codes
package pso_pkg;
	typedef enum logic [1:0] {
		PSO_PRECISION_FIELD_16 = 2'h0,
		PSO_PRECISION_FIELD_18 = 2'h1,
		PSO_PRECISION_FIELD_20 = 2'h2,
		PSO_PRECISION_FIELD_24 = 2'h3
	} pso_precision_field_t;
	typedef enum logic [1:0] {
		PSO_MAP_STRAIGHT = 2'h0,
		PSO_MAP_LEFT     = 2'h1,
		PSO_MAP_RIGHT    = 2'h2,
		PSO_MAP_SWAP     = 2'h3
	} pso_map_t;
	typedef enum {PSO_IDLE, PSO_RUN} pso_state_t;
endpackage

// file: rtl/pso_fifo.sv
// Purpose: Sample FIFO ahead of the serialiser
// Assumes: Single clock
// Notes:   Honest full and empty through valid and ready
`timescale 1ns/1ns
`default_nettype none
module pso_fifo #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             nrst,
	// Fill side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// Drain side
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;

	// Flags
	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem[rd_q];

	// Pointers and count
	always_ff @(posedge clk) begin
		if (!nrst) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			if (pop) rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Storage
	always_ff @(posedge clk) begin
		if (push) mem[wr_q] <= in_data;
	end
endmodule
`default_nettype wire

// file: rtl/pso_serial_out.sv
// Purpose: Serial PCM output with clock control registers
// Assumes: clk is the oversampling clock at 25 MHz; byte register port
// Notes:   Samples arrive as left/right pairs through an 8-word FIFO
`timescale 1ns/1ns
`default_nettype none
`include "pso_defines.svh"
// Contract
// - Bit clock is oversampling clock over two times divider plus one
// - 32 slots per frame in 16-bit, 64 slots otherwise
// - Divider is factor/64 minus one, or factor/128 minus one
// - Bit-order one sends LSB first, zero sends MSB first
// - Padding bit selects right or left padding, ignored in 16-bit mode
// - Polarity one drives frame clock low for left; zero inverts
// - Format bit zero is I2S framing, one alternative; resets zero
// - Edge bit zero changes data on falling edge; one swaps edges
// - Precision code selects 16, 18, 20 or 24-bit samples
// - Cross-map selects straight, duplicate left, duplicate right, swap
// - Post-divider five-bit field divides VCO; resets to seven
// - Core may update post-divider; software may also write it; the code takes core updates in clock-mode zero only
// - 16-bit 44.1 kHz fraction from high byte and low companion
// - Clock-mode one keeps oversampling clock fixed at user value
// - Clock-mode zero tracks 512, 384 or 256 times, default 256
// - Tracking default oversampling clock is 12.288 MHz
// - Oversampling clock from master, input divider, feedback, fraction, post-divider
// - General fraction is 256 times high byte plus low byte
module pso_serial_out #(
	parameter int   SW       = 24,
	parameter int   DEPTH    = 8,
	parameter logic [7:0] FRAC_44K1_LOW = 8'h00
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          nrst,
	// Register port
	input  wire logic [7:0]    reg_addr,
	input  wire logic          reg_wr,
	input  wire logic [7:0]    reg_wdata,
	output logic      [7:0]    reg_rdata,
	// Core post-divider update
	input  wire logic          core_pdiv_wr,
	input  wire logic [4:0]    core_pdiv,
	// Sample stream
	input  wire logic          smp_valid,
	input  wire logic [SW-1:0] smp_left,
	input  wire logic [SW-1:0] smp_right,
	output logic               smp_ready,
	// Clock control outputs
	output logic [4:0]         pll_post_divider,
	output logic [15:0]        pll_frac,
	output logic [15:0]        pll_frac_44k1,
	output logic               oversampling_clock_fixed,
	// DAC pins
	output logic               transmit_bit_clock,
	output logic               left_right_clock,
	output logic               serial_data
);
	logic [7:0] frac_h_q, div_q, cfg_q, map_q, pdiv_q, mode_q, fl_q, fh_q;
	logic [7:0] rdata_q;
	logic [7:0] div_cnt_q;
	logic       sck_q, lr_q, sd_q;
	logic [5:0] slot_q;
	logic       side_q;
	logic       spill_q;
	logic [SW-1:0] left_q, right_q;
	pso_pkg::pso_state_t st_q;

	// Register write strobes
	wire wr_frac_h = reg_wr && (reg_addr == `PSO_ADDR_FRAC_44K1_H);
	wire wr_div    = reg_wr && (reg_addr == `PSO_ADDR_BCLK_DIV);
	wire wr_cfg    = reg_wr && (reg_addr == `PSO_ADDR_SO_CONFIG);
	wire wr_map    = reg_wr && (reg_addr == `PSO_ADDR_CROSS_MAP);
	wire wr_pdiv   = reg_wr && (reg_addr == `PSO_ADDR_POST_DIV);
	wire wr_mode   = reg_wr && (reg_addr == `PSO_ADDR_OVERSAMPLING_CLOCK_MODE);
	wire wr_fl     = reg_wr && (reg_addr == `PSO_ADDR_FRAC_LOW);
	wire wr_fh     = reg_wr && (reg_addr == `PSO_ADDR_FRAC_HIGH);

	// Configuration fields
	wire pso_pkg::pso_precision_field_t precision_field = pso_pkg::pso_precision_field_t'(cfg_q[1:0]);
	wire pso_pkg::pso_map_t  xmap = pso_pkg::pso_map_t'(map_q[1:0]);
	wire lsb_first = cfg_q[`PSO_BIT_ORDER];
	wire left_pad  = cfg_q[`PSO_BIT_PAD];
	wire pol_i2s   = cfg_q[`PSO_BIT_POL];
	wire alt_fmt   = cfg_q[`PSO_BIT_FMT];
	wire edge_rise = cfg_q[`PSO_BIT_EDGE];
	wire wide      = (precision_field != pso_pkg::PSO_PRECISION_FIELD_16);

	// Register writes; in clock-mode zero a core update of post-divider takes priority over software
	always_ff @(posedge clk) begin
		if (!nrst) begin
			frac_h_q <= `PSO_RST_FRAC_44K1_H;
			div_q    <= `PSO_RST_BCLK_DIV;
			cfg_q    <= `PSO_RST_SO_CONFIG;
			map_q    <= `PSO_RST_CROSS_MAP;
			pdiv_q   <= `PSO_RST_POST_DIV;
			mode_q   <= `PSO_RST_OVERSAMPLING_CLOCK_MODE;
			fl_q     <= `PSO_RST_FRAC_LOW;
			fh_q     <= `PSO_RST_FRAC_HIGH;
		end else begin
			if (wr_frac_h) frac_h_q <= reg_wdata;
			if (wr_div) div_q <= reg_wdata;
			if (wr_cfg) cfg_q <= {1'b0, reg_wdata[6:0]};
			if (wr_map) map_q <= {6'h00, reg_wdata[1:0]};
			if (core_pdiv_wr && !mode_q[`PSO_BIT_MODE]) pdiv_q <= {3'h0, core_pdiv};
			else if (wr_pdiv) pdiv_q <= reg_wdata & `PSO_POST_DIV_MASK;
			if (wr_mode) mode_q <= {7'h00, reg_wdata[`PSO_BIT_MODE]};
			if (wr_fl) fl_q <= reg_wdata;
			if (wr_fh) fh_q <= reg_wdata;
		end
	end

	// Read mux
	wire [7:0] rd_mux =
		(reg_addr == `PSO_ADDR_FRAC_44K1_H) ? frac_h_q :
		(reg_addr == `PSO_ADDR_BCLK_DIV)    ? div_q :
		(reg_addr == `PSO_ADDR_SO_CONFIG)   ? cfg_q :
		(reg_addr == `PSO_ADDR_CROSS_MAP)   ? map_q :
		(reg_addr == `PSO_ADDR_POST_DIV)    ? pdiv_q :
		(reg_addr == `PSO_ADDR_OVERSAMPLING_CLOCK_MODE)   ? mode_q :
		(reg_addr == `PSO_ADDR_FRAC_LOW)    ? fl_q :
		(reg_addr == `PSO_ADDR_FRAC_HIGH)   ? fh_q : 8'h00;

	// Registered read data and clock control outputs
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rdata_q          <= 8'h00;
			pll_post_divider <= 5'h07;
			pll_frac         <= 16'h0000;
			pll_frac_44k1    <= 16'h0000;
			oversampling_clock_fixed       <= 1'b0;
		end else begin
			rdata_q          <= rd_mux;
			pll_post_divider <= pdiv_q[4:0];
			pll_frac         <= {fh_q, fl_q};
			pll_frac_44k1    <= {frac_h_q, FRAC_44K1_LOW};
			oversampling_clock_fixed       <= mode_q[`PSO_BIT_MODE];
		end
	end
	assign reg_rdata = rdata_q;

	// Sample FIFO
	logic          f_valid;
	logic [2*SW-1:0] f_data;
	wire           frame_end;
	wire           take;
	pso_fifo #(.WIDTH(2*SW), .DEPTH(DEPTH)) u_fifo (
		.clk       (clk),
		.nrst      (nrst),
		.in_valid  (smp_valid),
		.in_data   ({smp_left, smp_right}),
		.in_ready  (smp_ready),
		.out_valid (f_valid),
		.out_data  (f_data),
		.out_ready (take)
	);

	// Bit clock half-period tick
	// Compare with >= so a divider lowered mid-count does not wrap the counter
	wire half_tick = (div_cnt_q >= div_q);
	wire fall      = half_tick && sck_q;
	wire rise      = half_tick && !sck_q;
	wire launch    = edge_rise ? rise : fall;
	wire [5:0] last_slot = wide ? 6'(`PSO_SLOTS_32 / 2 - 1) : 6'(`PSO_SLOTS_16 / 2 - 1);
	assign frame_end = launch && side_q && (slot_q == last_slot) && (st_q == pso_pkg::PSO_RUN);
	// A pair leaves the FIFO when it is loaded: on start from idle or at a frame end
	assign take      = launch && (frame_end || (st_q == pso_pkg::PSO_IDLE));

	// Sample width from precision
	function automatic logic [4:0] precision_field_bits(input logic [1:0] p);
		case (p)
			2'h0:    precision_field_bits = 5'd16;
			2'h1:    precision_field_bits = 5'd18;
			2'h2:    precision_field_bits = 5'd20;
			default: precision_field_bits = 5'd24;
		endcase
	endfunction
	wire [4:0] nbits = precision_field_bits(cfg_q[1:0]);

	// Cross-map of the current pair
	wire [SW-1:0] map_l = (xmap == pso_pkg::PSO_MAP_RIGHT || xmap == pso_pkg::PSO_MAP_SWAP)
		? right_q : left_q;
	wire [SW-1:0] map_r = (xmap == pso_pkg::PSO_MAP_LEFT || xmap == pso_pkg::PSO_MAP_SWAP)
		? left_q : right_q;
	wire [SW-1:0] word  = side_q ? map_r : map_l;

	// Slot to bit position
	wire [4:0] half_slots = wide ? 5'd31 : 5'd15;
	wire [4:0] slot_i     = slot_q[4:0];
	wire       i2s_delay  = !alt_fmt;
	wire [4:0] eff_slot   = slot_i;
	wire [4:0] pad        = half_slots + 5'd1 - nbits;
	wire [4:0] data_start = (wide && !left_pad) ? pad : 5'd0;
	wire [4:0] idx        = eff_slot - data_start;
	wire       in_word    = (eff_slot >= data_start) && (idx < nbits);
	wire [4:0] bitpos     = lsb_first ? idx : nbits - 5'd1 - idx;
	wire       next_bit   = in_word ? word[bitpos] : 1'b0;

	// Frame state: bit clock, slot counter, frame clock, data
	always_ff @(posedge clk) begin
		if (!nrst) begin
			div_cnt_q <= 8'h00;
			sck_q     <= 1'b0;
			slot_q    <= 6'h00;
			side_q    <= 1'b0;
			sd_q      <= 1'b0;
			spill_q   <= 1'b0;
			lr_q      <= 1'b1;
			st_q      <= pso_pkg::PSO_IDLE;
			left_q    <= '0;
			right_q   <= '0;
		end else begin
			div_cnt_q <= half_tick ? 8'h00 : div_cnt_q + 8'h01;
			if (half_tick) sck_q <= !sck_q;
			case (st_q)
				pso_pkg::PSO_IDLE: begin
					if (launch && f_valid) begin
						st_q    <= pso_pkg::PSO_RUN;
						left_q  <= f_data[2*SW-1:SW];
						right_q <= f_data[SW-1:0];
						slot_q  <= 6'h00;
						side_q  <= 1'b0;
					end
				end
				pso_pkg::PSO_RUN: begin
					if (launch) begin
						// I2S sends each bit one slot late; a half's last bit opens the next
						sd_q    <= i2s_delay ? spill_q : next_bit;
						spill_q <= next_bit;
						lr_q <= side_q ^ !pol_i2s;
						if (slot_q == last_slot) begin
							slot_q <= 6'h00;
							side_q <= !side_q;
							if (side_q) begin
								st_q    <= f_valid ? pso_pkg::PSO_RUN : pso_pkg::PSO_IDLE;
								left_q  <= f_data[2*SW-1:SW];
								right_q <= f_data[SW-1:0];
							end
						end else begin
							slot_q <= slot_q + 6'h01;
						end
					end
				end
				default: st_q <= pso_pkg::PSO_IDLE;
			endcase
		end
	end

	assign transmit_bit_clock = sck_q;
	assign left_right_clock   = lr_q;
	assign serial_data        = sd_q;

	// Assertions
	property p_div_reset;
		@(posedge clk) $rose(nrst) |-> div_q == 8'h03;
	endproperty
	a_div_reset: assert property (p_div_reset)
		else $error("divider reset value wrong");
	property p_half_period;
		@(posedge clk) disable iff (!nrst)
		$changed(sck_q) && $stable(div_q) |=> !$changed(sck_q) [*1] or div_q == 8'h00;
	endproperty
	a_half_period: assert property (p_half_period)
		else $error("bit clock toggled too fast");
	property p_slots;
		@(posedge clk) disable iff (!nrst) frame_end |-> slot_q == (wide ? 6'd31 : 6'd15);
	endproperty
	a_slots: assert property (p_slots)
		else $error("frame slot count wrong");
	property p_cfg_rst;
		@(posedge clk) $rose(nrst) |-> cfg_q[`PSO_BIT_FMT] == 1'b0 && cfg_q == 8'h21;
	endproperty
	a_cfg_rst: assert property (p_cfg_rst)
		else $error("config reset value wrong");
	property p_pdiv_rst;
		@(posedge clk) $rose(nrst) |-> pdiv_q == 8'h07 && map_q == 8'h00;
	endproperty
	a_pdiv_rst: assert property (p_pdiv_rst)
		else $error("post divider or map reset wrong");
	property p_zero_pad;
		@(posedge clk) disable iff (!nrst) launch && st_q == pso_pkg::PSO_RUN && !in_word
			|=> !(i2s_delay ? spill_q : sd_q);
	endproperty
	a_zero_pad: assert property (p_zero_pad)
		else $error("padding slot not zero");
	property p_lr_pol;
		@(posedge clk) disable iff (!nrst) launch && st_q == pso_pkg::PSO_RUN
			|=> lr_q == ($past(side_q) ^ !$past(pol_i2s));
	endproperty
	a_lr_pol: assert property (p_lr_pol)
		else $error("frame clock polarity wrong");
	property p_core_pdiv;
		@(posedge clk) disable iff (!nrst) core_pdiv_wr && !mode_q[0]
			|=> pdiv_q[4:0] == $past(core_pdiv) ##1 pll_post_divider == $past(core_pdiv, 2);
	endproperty
	a_core_pdiv: assert property (p_core_pdiv)
		else $error("core post divider update lost");
	c_frame: cover property (@(posedge clk) disable iff (!nrst) frame_end);
	c_wide: cover property (@(posedge clk) disable iff (!nrst) frame_end && wide);
	c_swap: cover property (@(posedge clk) disable iff (!nrst)
		frame_end && xmap == pso_pkg::PSO_MAP_SWAP);
endmodule
`default_nettype wire

// file: sim/pso_dac_model.sv
// Purpose: Behavioural DAC that takes in the serial PCM stream
// Assumes: Config copies give it the sampling edge and the framing delay
// Notes:   Stores one word per half frame with its frame clock level
`timescale 1ns/1ns
`default_nettype none
module pso_dac_model (
	// DAC pins
	input wire logic sck,
	input wire logic lrck,
	input wire logic sd,
	// Framing copies
	input wire logic rise_send,
	input wire logic no_delay
);
	logic [31:0] wq [$];
	logic        lq [$];
	logic [31:0] sh = 32'h00000000;
	logic [31:0] pre;
	logic        lr_q = 1'b1;
	int          slot = 0;
	int          half_len = 0;
	time         t_q = 0;
	time         per = 0;
	// Sampling edge is the one opposite to the launch edge
	wire         smp_ev = sck ^ rise_send;
	// Bit clock period, rising to rising
	always @(posedge sck) begin
		per = $time - t_q;
		t_q = $time;
	end
	// Shift in, and close a word at each frame clock change
	always @(posedge smp_ev) begin
		pre = sh;
		sh = {sh[30:0], sd};
		slot = slot + 1;
		if (lrck !== lr_q) begin
			half_len = slot - 1;
			slot = 1;
			// With the I2S delay the closing half's last bit is the one just taken
			wq.push_back(no_delay ? pre : sh);
			lq.push_back(lr_q);
			lr_q = lrck;
		end
	end
endmodule
`default_nettype wire

// file: sim/pcm_serial_output_clocking_tb.sv
// Purpose: Self-checking bench of the serial PCM output block
// Assumes: 25 MHz clk; inputs move 2 ns after the rising edge
// Notes:   Format rows in a table; registers, core update and FIFO by hand
`timescale 1ns/1ns
`default_nettype none
module pcm_serial_output_clocking_tb;
	typedef struct packed {
		logic [7:0]  cfg, map, div;
		logic [23:0] l, r;
	} pso_row_t;
	// Design inputs
	logic        clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, core_pdiv_wr = 1'b0;
	logic        smp_valid = 1'b0;
	logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, cfg = 8'h21;
	logic [4:0]  core_pdiv = 5'h00;
	logic [23:0] smp_left = 24'h000000, smp_right = 24'h000000;
	// Design outputs
	logic [7:0]  reg_rdata;
	logic [4:0]  pll_post_divider;
	logic [15:0] pll_frac, pll_frac_44k1;
	logic        smp_ready, oversampling_clock_fixed, sck, lrck, sdata;
	int          fail_count = 0;
	int          total_checks = 0;
	// Register map: address, reset value, writable bits
	logic [7:0]  ra [8] = '{8'h52, 8'h54, 8'h55, 8'h56, 8'h61, 8'h63, 8'h64, 8'h65};
	logic [7:0]  rr [8] = '{8'h00, 8'h03, 8'h21, 8'h00, 8'h07, 8'h00, 8'h46, 8'h5B};
	logic [7:0]  rm [8] = '{8'hFF, 8'hFF, 8'h7F, 8'h03, 8'h1F, 8'h01, 8'hFF, 8'hFF};
	// Rows: config, cross map, divider, left sample, right sample
	pso_row_t    rows [5] = '{
		'{8'h30, 8'h00, 8'h01, 24'hC3C3C3, 24'h3C3C3C},
		'{8'h65, 8'h01, 8'h00, 24'hD34D34, 24'h2CB2CB},
		'{8'h1A, 8'h02, 8'h02, 24'hBBBBBB, 24'h444444},
		'{8'h4F, 8'h03, 8'h01, 24'hA5F00F, 24'h5A0FF0},
		'{8'h23, 8'h00, 8'h00, 24'hA5F00F, 24'h5A0FF0}};

	pso_serial_out dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .core_pdiv_wr(core_pdiv_wr),
		.core_pdiv(core_pdiv), .smp_valid(smp_valid), .smp_left(smp_left),
		.smp_right(smp_right), .smp_ready(smp_ready), .pll_post_divider(pll_post_divider),
		.pll_frac(pll_frac), .pll_frac_44k1(pll_frac_44k1), .oversampling_clock_fixed(oversampling_clock_fixed),
		.transmit_bit_clock(sck), .left_right_clock(lrck), .serial_data(sdata));
	pso_dac_model dac (.sck(sck), .lrck(lrck), .sd(sdata), .rise_send(cfg[2]),
		.no_delay(cfg[3]));

	// 40 ns clock
	always #20 clk = ~clk;

	task automatic tick;
		@(posedge clk);
		#2;
	endtask
	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rst(int n);
		nrst = 1'b0;
		repeat (n) tick;
		nrst = 1'b1;
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		tick;
		reg_wr = 1'b0;
		tick;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] exp);
		reg_addr = a;
		tick;
		check($sformatf("reg %h", a), exp, reg_rdata);
	endtask
	// Holds valid up; the caller lowers it after the batch
	task automatic push(logic [23:0] l, logic [23:0] r);
		int k;
		smp_left = l;
		smp_right = r;
		smp_valid = 1'b1;
		k = 0;
		while (smp_ready !== 1'b1 && k < 3000) begin
			tick;
			k++;
		end
		tick;
		if (k >= 3000) begin
			fail_count++;
			report_and_stop;
		end
	endtask
	// Expected word: precision bits, first sent at the top of the field
	function automatic logic [31:0] enc(logic [23:0] x, logic [7:0] c);
		int          p;
		logic [31:0] f;
		p = (c[1:0] == 2'h3) ? 24 : 16 + 2 * c[1:0];
		f = 32'h00000000;
		for (int j = 0; j < p; j++)
			f[c[6] ? p - 1 - j : j] = x[j];
		if (p != 16 && c[5])
			f = f << (32 - p);
		return f;
	endfunction

	// Main sequence
	initial begin
		int          n0, k, acc;
		logic        hit;
		logic [31:0] el, er, mk;
		rst(12);
		for (int i = 0; i < 8; i++) rd(ra[i], rr[i]);
		for (int i = 0; i < 8; i++) wr(ra[i], 8'hF0 | i[7:0]);
		for (int i = 0; i < 8; i++) rd(ra[i], (8'hF0 | i[7:0]) & rm[i]);
		rd(8'h57, 8'h00);
		check("post div", 32'h14, pll_post_divider);
		check("frac", 32'hF7F6, pll_frac);
		check("frac 44k1", 32'hF000, pll_frac_44k1);
		check("fixed", 32'h1, oversampling_clock_fixed);
		core_pdiv = 5'h03;
		core_pdiv_wr = 1'b1;
		tick;
		core_pdiv_wr = 1'b0;
		tick;
		rd(8'h61, 8'h14);
		wr(8'h63, 8'h00);
		core_pdiv = 5'h09;
		core_pdiv_wr = 1'b1;
		wr(8'h61, 8'h02);
		core_pdiv_wr = 1'b0;
		rd(8'h61, 8'h09);
		check("tracking", 32'h0, oversampling_clock_fixed);
		check("core div", 32'h09, pll_post_divider);
		// FIFO fills until refused, then frees a place
		rst(2);
		smp_valid = 1'b1;
		acc = 0;
		for (k = 0; k < 12; k++) begin
			acc += (smp_ready === 1'b1);
			tick;
		end
		check("fifo full", 32'h0, smp_ready);
		check("fifo depth", 32'h1, acc >= 8 && acc <= 10);
		smp_valid = 1'b0;
		k = 0;
		while (smp_ready !== 1'b1 && k < 3000) begin
			tick;
			k++;
		end
		check("fifo drains", 32'h1, smp_ready);
		// Framing rows
		for (int i = 0; i < 5; i++) begin
			rst(2);
			cfg = rows[i].cfg;
			wr(8'h55, rows[i].cfg);
			wr(8'h56, rows[i].map);
			wr(8'h54, rows[i].div);
			n0 = dac.wq.size();
			repeat (4) push(rows[i].l, rows[i].r);
			smp_valid = 1'b0;
			k = 0;
			while (dac.wq.size() < n0 + 6 && k < 6000) begin
				tick;
				k++;
			end
			if (k >= 6000) begin
				fail_count++;
				report_and_stop;
			end
			el = enc(rows[i].map[1] ? rows[i].r : rows[i].l, cfg);
			er = enc(rows[i].map[0] ? rows[i].l : rows[i].r, cfg);
			mk = (cfg[1:0] == 2'h0) ? 32'h0000FFFF : 32'hFFFFFFFF;
			hit = 1'b0;
			for (int j = n0; j + 1 < dac.wq.size(); j++)
				if ((dac.wq[j] & mk) === el && dac.lq[j] === ~cfg[4]
					&& (dac.wq[j+1] & mk) === er && dac.lq[j+1] === cfg[4])
					hit = 1'b1;
			check($sformatf("frame %0d", i), 32'h1, hit);
			check("slots", (cfg[1:0] == 2'h0) ? 16 : 32, dac.half_len);
			check("bit period", 80 * (rows[i].div + 1), dac.per[31:0]);
		end
		report_and_stop;
	end
endmodule
`default_nettype wire
